// >>> include/sba_pkg.sv
package sba_pkg;

    // Command header layout and decode values
    localparam int SBA_HDR_TYPE_LSB = 29;
    localparam int SBA_HDR_SUB_LSB = 27;
    localparam int SBA_HDR_OPC_LSB = 24;
    localparam int SBA_HDR_SUBOP_LSB = 16;
    localparam int SBA_HDR_LEN_LSB = 0;
    localparam logic [2:0] SBA_GRAPHICS_PIPE_COMMAND_TYPE = 3'h3;
    localparam logic [1:0] SBA_COMMON_PIPE_SUBTYPE = 2'h0;
    localparam logic [2:0] SBA_NON_PIPELINED_OPCODE = 3'h1;
    localparam logic [7:0] SBA_SUB_OPCODE = 8'h01;
    localparam logic [7:0] SBA_LEN_DEFAULT = 8'h08;
    localparam logic [8:0] SBA_LEN_BIAS_AFTER_HDR = 9'h001;

    // Base dword layout
    localparam int SBA_NUM_BASES = 5;
    localparam int SBA_BASE_LSB = 12;
    localparam int SBA_MOCS_LSB = 8;
    localparam int SBA_SL_MOCS_LSB = 4;
    localparam int SBA_SL_WT_BIT = 3;
    localparam int SBA_MODIFY_BIT = 0;
    localparam logic [2:0] SBA_DW_FIRST = 3'h1;
    localparam logic [2:0] SBA_DW_LAST = 3'h5;
    localparam logic [2:0] SBA_DW_BEYOND = 3'h6;

    // Base slots, in dword order
    localparam int SBA_B_GENERAL = 0;
    localparam int SBA_B_SURFACE = 1;
    localparam int SBA_B_DYNAMIC = 2;
    localparam int SBA_B_INDIRECT = 3;
    localparam int SBA_B_INSTR = 4;

    // Control value bit positions
    localparam int SBA_MOCS_DISPLAY_BIT = 2;
    localparam int SBA_MOCS_LLC_BIT = 1;
    localparam int SBA_MOCS_L3_BIT = 0;

    // Register map and reset values
    localparam logic [7:0] SBA_OFS_CMD = 8'h00;
    localparam logic [7:0] SBA_OFS_STATUS = 8'h04;
    localparam logic [7:0] SBA_OFS_MODE = 8'h08;
    localparam logic [7:0] SBA_OFS_BASE0 = 8'h10;
    localparam logic [7:0] SBA_OFS_STEP = 8'h04;
    localparam logic [19:0] SBA_BASE_RST = 20'h00000;
    localparam logic [3:0] SBA_MOCS_RST = 4'h0;

    typedef enum logic [2:0] {
        SBA_IDLE = 3'b001,
        SBA_COLLECT = 3'b010,
        SBA_FLUSH = 3'b100
    } sba_parse_t;

    typedef enum logic [3:0] {
        SBA_CL_STATELESS = 4'h0,
        SBA_CL_GEN_INDIRECT = 4'h1,
        SBA_CL_DYNAMIC = 4'h2,
        SBA_CL_PUSH_CONST = 4'h3,
        SBA_CL_INSTR = 4'h4,
        SBA_CL_SYS_ROUTINE = 4'h5,
        SBA_CL_SURFACE = 4'h6,
        SBA_CL_INDIRECT_OBJ = 4'h7,
        SBA_CL_NONE = 4'h8
    } sba_class_t;

    typedef struct packed {
        sba_parse_t st;
        logic [8:0] remain;
        logic [2:0] dw_idx;
        logic [SBA_NUM_BASES-1:0][19:0] base;
        logic [SBA_NUM_BASES-1:0][3:0] mocs;
        logic [3:0] sl_mocs;
        logic sl_wt;
        logic [SBA_NUM_BASES-1:0][19:0] p_base;
        logic [SBA_NUM_BASES-1:0][3:0] p_mocs;
        logic [3:0] p_sl_mocs;
        logic p_sl_wt;
        logic cb_off_dis;
        logic [7:0] ignored_cnt;
        logic [7:0] commit_cnt;
        logic flush_req;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic x_valid;
        logic [31:0] x_addr;
        logic [3:0] x_mocs;
        logic x_wt;
    } sba_state_t;

endpackage

// >>> hw/sba_state_base.sv
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
// Function
// [RL1] Recognise setup header and its length
// [RL2] Dword 1 loads general base
// [RL3] General control value for indirect state
// [RL4] Separate control value for stateless accesses
// [RL5] Bit 3 picks stateless write-through
// [RL6] Modify-enable gates each dword's load
// [RL7] Dword 2 loads surface base, control
// [RL8] Dword 3 loads dynamic base, control
// [RL9] Push constants skip dynamic control value
// [RL10] Dword 4 loads indirect-object base, control
// [RL11] Bases always applied; zero disables relocation
// [RL12] Address is base plus relative offset
// [RL13] Stateless accesses use general base
// [RL14] Sampler, viewport, descriptor fetches use dynamic
// [RL15] Push constants: dynamic base or none
// [RL16] Both instruction streams use instruction base
// [RL17] Binding and surface fetches use surface
// [RL18] Other accesses get no base
// [RL19] Full flush before new bases apply
// [RL20] Software reissues pointer commands after change
// [RL21] Control bits: display, last-level, third-level
// [RL22] Dword 5 loads instruction base
// [RL23] Reserved command bits are ignored
module sba_state_base (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic flush_req_out,
    input wire logic flush_done_in,
    input wire logic req_valid_in,
    input wire logic [3:0] req_class_in,
    input wire logic [31:0] req_offset_in,
    input wire logic [3:0] req_mocs_in,
    output logic xlat_valid_out,
    output logic [31:0] xlat_addr_out,
    output logic [3:0] xlat_mocs_out,
    output logic display_data_flag_out,
    output logic last_level_cache_ctrl_out,
    output logic third_level_cache_ctrl_out,
    output logic write_through_out
);

    sba_pkg::sba_state_t r_ff;
    sba_pkg::sba_state_t nxt_r;
    logic acc_fire;
    logic cmd_fire;
    logic hdr_match;
    logic [2:0] slot_idx;

    assign acc_fire = psel_in && penable_in && r_ff.pready && !r_ff.pslverr;
    assign cmd_fire = acc_fire && pwrite_in && (paddr_in == sba_pkg::SBA_OFS_CMD);
    assign slot_idx = r_ff.dw_idx - sba_pkg::SBA_DW_FIRST;

    // Reserved bits 15:8 are not compared
    assign hdr_match =
        (pwdata_in[31:sba_pkg::SBA_HDR_TYPE_LSB] == sba_pkg::SBA_GRAPHICS_PIPE_COMMAND_TYPE) && // see [RL1] [RL23]
        (pwdata_in[sba_pkg::SBA_HDR_TYPE_LSB-1:sba_pkg::SBA_HDR_SUB_LSB] == sba_pkg::SBA_COMMON_PIPE_SUBTYPE) &&
        (pwdata_in[sba_pkg::SBA_HDR_SUB_LSB-1:sba_pkg::SBA_HDR_OPC_LSB] == sba_pkg::SBA_NON_PIPELINED_OPCODE) &&
        (pwdata_in[sba_pkg::SBA_HDR_OPC_LSB-1:sba_pkg::SBA_HDR_SUBOP_LSB] == sba_pkg::SBA_SUB_OPCODE);

    always_comb begin
        logic [19:0] sel_base;
        logic [7:0] ofs;
        logic hit;
        sel_base = 20'h00000;
        ofs = 8'h00;
        hit = 1'b0;
        nxt_r = r_ff;

        // Bus answer: decode in setup, ready in first access cycle
        nxt_r.pready = 1'b0;
        if (psel_in && !penable_in) begin
            nxt_r.pready = 1'b1;
            nxt_r.pslverr = 1'b0;
            nxt_r.prdata = 32'h00000000;
            if (paddr_in == sba_pkg::SBA_OFS_CMD) begin
                hit = 1'b1;
                nxt_r.pslverr = pwrite_in && (r_ff.st == sba_pkg::SBA_FLUSH);
            end else if (paddr_in == sba_pkg::SBA_OFS_STATUS) begin
                hit = 1'b1;
                nxt_r.prdata = {8'h00, r_ff.commit_cnt, r_ff.ignored_cnt, 6'h00,
                                r_ff.flush_req, r_ff.st == sba_pkg::SBA_COLLECT};
            end else if (paddr_in == sba_pkg::SBA_OFS_MODE) begin
                hit = 1'b1;
                nxt_r.prdata = {31'h00000000, r_ff.cb_off_dis};
            end
            for (int i = 0; i < sba_pkg::SBA_NUM_BASES; i++) begin
                ofs = sba_pkg::SBA_OFS_BASE0 + 8'(i * 4);
                if (paddr_in == ofs) begin
                    hit = 1'b1;
                    nxt_r.prdata = {r_ff.base[i], r_ff.mocs[i], 8'h00};
                    if (i == sba_pkg::SBA_B_GENERAL) begin
                        nxt_r.prdata[7:3] = {r_ff.sl_mocs, r_ff.sl_wt};
                    end
                end
            end
            if (!hit) begin
                nxt_r.pslverr = 1'b1;
            end
        end

        if (acc_fire && pwrite_in && (paddr_in == sba_pkg::SBA_OFS_MODE)) begin
            nxt_r.cb_off_dis = pwdata_in[0];
        end

        // Command parser
        unique case (r_ff.st)
            sba_pkg::SBA_IDLE: begin
                if (cmd_fire) begin
                    if (hdr_match) begin // see [RL1]
                        nxt_r.st = sba_pkg::SBA_COLLECT;
                        nxt_r.remain = {1'b0, pwdata_in[7:sba_pkg::SBA_HDR_LEN_LSB]} + sba_pkg::SBA_LEN_BIAS_AFTER_HDR;
                        nxt_r.dw_idx = sba_pkg::SBA_DW_FIRST;
                        nxt_r.p_base = r_ff.base;
                        nxt_r.p_mocs = r_ff.mocs;
                        nxt_r.p_sl_mocs = r_ff.sl_mocs;
                        nxt_r.p_sl_wt = r_ff.sl_wt;
                    end else begin
                        nxt_r.ignored_cnt = r_ff.ignored_cnt + 8'h01;
                    end
                end
            end
            sba_pkg::SBA_COLLECT: begin
                if (cmd_fire) begin
                    // Dwords past 5 are consumed without effect
                    if (r_ff.dw_idx <= sba_pkg::SBA_DW_LAST && pwdata_in[sba_pkg::SBA_MODIFY_BIT]) begin // see [RL6]
                        nxt_r.p_base[slot_idx] = pwdata_in[31:sba_pkg::SBA_BASE_LSB]; // see [RL2] [RL7] [RL8] [RL10] [RL22]
                        nxt_r.p_mocs[slot_idx] = pwdata_in[11:sba_pkg::SBA_MOCS_LSB]; // see [RL3] [RL7] [RL8] [RL10]
                        if (r_ff.dw_idx == sba_pkg::SBA_DW_FIRST) begin
                            nxt_r.p_sl_mocs = pwdata_in[7:sba_pkg::SBA_SL_MOCS_LSB]; // see [RL4]
                            nxt_r.p_sl_wt = pwdata_in[sba_pkg::SBA_SL_WT_BIT]; // see [RL5]
                        end
                    end
                    if (r_ff.dw_idx < sba_pkg::SBA_DW_BEYOND) begin
                        nxt_r.dw_idx = r_ff.dw_idx + 3'h1;
                    end
                    nxt_r.remain = r_ff.remain - 9'h001;
                    if (r_ff.remain == 9'h001) begin
                        nxt_r.st = sba_pkg::SBA_FLUSH;
                        nxt_r.flush_req = 1'b1; // see [RL19]
                    end
                end
            end
            sba_pkg::SBA_FLUSH: begin
                if (flush_done_in) begin // see [RL19]
                    nxt_r.base = r_ff.p_base;
                    nxt_r.mocs = r_ff.p_mocs;
                    nxt_r.sl_mocs = r_ff.p_sl_mocs;
                    nxt_r.sl_wt = r_ff.p_sl_wt;
                    nxt_r.flush_req = 1'b0;
                    nxt_r.st = sba_pkg::SBA_IDLE;
                    nxt_r.commit_cnt = r_ff.commit_cnt + 8'h01;
                end
            end
        endcase

        // Address relocation per access class
        nxt_r.x_valid = req_valid_in;
        if (req_valid_in) begin
            nxt_r.x_wt = 1'b0;
            nxt_r.x_mocs = req_mocs_in;
            sel_base = 20'h00000;
            unique case (req_class_in)
                sba_pkg::SBA_CL_STATELESS: begin
                    sel_base = r_ff.base[sba_pkg::SBA_B_GENERAL]; // see [RL13]
                    nxt_r.x_mocs = r_ff.sl_mocs; // see [RL4]
                    nxt_r.x_wt = r_ff.sl_wt && r_ff.sl_mocs[sba_pkg::SBA_MOCS_L3_BIT]; // see [RL5]
                end
                sba_pkg::SBA_CL_GEN_INDIRECT: begin
                    sel_base = r_ff.base[sba_pkg::SBA_B_GENERAL];
                    nxt_r.x_mocs = r_ff.mocs[sba_pkg::SBA_B_GENERAL]; // see [RL3]
                end
                sba_pkg::SBA_CL_DYNAMIC: begin
                    sel_base = r_ff.base[sba_pkg::SBA_B_DYNAMIC]; // see [RL14]
                    nxt_r.x_mocs = r_ff.mocs[sba_pkg::SBA_B_DYNAMIC];
                end
                sba_pkg::SBA_CL_PUSH_CONST: begin
                    sel_base = r_ff.cb_off_dis ? 20'h00000 : r_ff.base[sba_pkg::SBA_B_DYNAMIC]; // see [RL15]
                    nxt_r.x_mocs = req_mocs_in; // see [RL9]
                end
                sba_pkg::SBA_CL_INSTR, sba_pkg::SBA_CL_SYS_ROUTINE: begin
                    sel_base = r_ff.base[sba_pkg::SBA_B_INSTR]; // see [RL16]
                    nxt_r.x_mocs = r_ff.mocs[sba_pkg::SBA_B_INSTR];
                end
                sba_pkg::SBA_CL_SURFACE: begin
                    sel_base = r_ff.base[sba_pkg::SBA_B_SURFACE]; // see [RL17]
                    nxt_r.x_mocs = r_ff.mocs[sba_pkg::SBA_B_SURFACE];
                end
                sba_pkg::SBA_CL_INDIRECT_OBJ: begin
                    sel_base = r_ff.base[sba_pkg::SBA_B_INDIRECT]; // see [RL10]
                    nxt_r.x_mocs = r_ff.mocs[sba_pkg::SBA_B_INDIRECT];
                end
                default: begin
                    sel_base = 20'h00000; // see [RL18]
                end
            endcase
            nxt_r.x_addr = {sel_base, 12'h000} + req_offset_in; // see [RL11] [RL12]
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r_ff <= '0;
            r_ff.st <= sba_pkg::SBA_IDLE;
            r_ff.base <= {sba_pkg::SBA_NUM_BASES{sba_pkg::SBA_BASE_RST}};
            r_ff.mocs <= {sba_pkg::SBA_NUM_BASES{sba_pkg::SBA_MOCS_RST}};
            r_ff.sl_mocs <= sba_pkg::SBA_MOCS_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign prdata_out = r_ff.prdata;
    assign pready_out = r_ff.pready;
    assign pslverr_out = r_ff.pslverr;
    assign flush_req_out = r_ff.flush_req;
    assign xlat_valid_out = r_ff.x_valid;
    assign xlat_addr_out = r_ff.x_addr;
    assign xlat_mocs_out = r_ff.x_mocs;
    assign display_data_flag_out = r_ff.x_mocs[sba_pkg::SBA_MOCS_DISPLAY_BIT]; // see [RL21]
    assign last_level_cache_ctrl_out = r_ff.x_mocs[sba_pkg::SBA_MOCS_LLC_BIT]; // see [RL21]
    assign third_level_cache_ctrl_out = r_ff.x_mocs[sba_pkg::SBA_MOCS_L3_BIT]; // see [RL21]
    assign write_through_out = r_ff.x_wt;

    // Checks
    default clocking cb_main @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // Check helpers
    logic col_fire;
    logic col_load;
    assign col_fire = (r_ff.st == sba_pkg::SBA_COLLECT) && cmd_fire;
    assign col_load = col_fire && pwdata_in[0];

    a_hdr_accept: assert property ((r_ff.st == sba_pkg::SBA_IDLE) && cmd_fire && hdr_match // see [RL1]
        |=> (r_ff.st == sba_pkg::SBA_COLLECT) && (r_ff.remain == $past(pwdata_in[7:0]) + 9'h001))
        else $error("Header not accepted");

    a_hdr_reject: assert property ((r_ff.st == sba_pkg::SBA_IDLE) && cmd_fire && !hdr_match // see [RL1]
        |=> (r_ff.st == sba_pkg::SBA_IDLE) && (r_ff.ignored_cnt == $past(r_ff.ignored_cnt) + 8'h01))
        else $error("Foreign header not ignored");

    a_general_load: assert property ((r_ff.st == sba_pkg::SBA_COLLECT) && cmd_fire && (r_ff.dw_idx == 3'h1) // see [RL2]
        && pwdata_in[0] |=> (r_ff.p_base[0] == $past(pwdata_in[31:12])) && (r_ff.p_sl_mocs == $past(pwdata_in[7:4])))
        else $error("General dword not loaded");

    a_modify_hold: assert property ((r_ff.st == sba_pkg::SBA_COLLECT) && cmd_fire && !pwdata_in[0] // see [RL6]
        |=> (r_ff.p_base == $past(r_ff.p_base)) && (r_ff.p_mocs == $past(r_ff.p_mocs)))
        else $error("Disabled dword changed state");

    a_flush_hold: assert property ((r_ff.st == sba_pkg::SBA_FLUSH) && !flush_done_in // see [RL19]
        |=> (r_ff.base == $past(r_ff.base)) && flush_req_out)
        else $error("Bases changed before flush done");

    a_flush_commit: assert property ((r_ff.st == sba_pkg::SBA_FLUSH) && flush_done_in // see [RL19]
        |=> (r_ff.base == $past(r_ff.p_base)) && (r_ff.st == sba_pkg::SBA_IDLE) && !flush_req_out)
        else $error("Commit after flush wrong");

    a_dyn_reloc: assert property (req_valid_in && (req_class_in == sba_pkg::SBA_CL_DYNAMIC) // see [RL12]
        |=> xlat_valid_out && (xlat_addr_out == {$past(r_ff.base[2]), 12'h000} + $past(req_offset_in)))
        else $error("Dynamic relocation wrong");

    a_none_reloc: assert property (req_valid_in && (req_class_in == sba_pkg::SBA_CL_NONE) // see [RL18]
        |=> xlat_addr_out == $past(req_offset_in))
        else $error("Unrelocated access got a base");

    a_push_mocs: assert property (req_valid_in && (req_class_in == sba_pkg::SBA_CL_PUSH_CONST) // see [RL9]
        |=> xlat_mocs_out == $past(req_mocs_in))
        else $error("Push constant control value wrong");

    a_apb_answer: assert property (psel_in && !penable_in ##1 psel_in && penable_in
        |-> pready_out)
        else $error("Bus answer late");

    a_gen_mocs_load: assert property (col_load && (r_ff.dw_idx == 3'h1) // see [RL3]
        |=> r_ff.p_mocs[0] == $past(pwdata_in[11:8]))
        else $error("General control not loaded");

    a_sl_wt_load: assert property (col_load && (r_ff.dw_idx == 3'h1) // see [RL5]
        |=> r_ff.p_sl_wt == $past(pwdata_in[3]))
        else $error("Write policy not loaded");

    a_surf_load: assert property (col_load && (r_ff.dw_idx == 3'h2) // see [RL7]
        |=> (r_ff.p_base[1] == $past(pwdata_in[31:12])) && (r_ff.p_mocs[1] == $past(pwdata_in[11:8])))
        else $error("Surface dword not loaded");

    a_dyn_load: assert property (col_load && (r_ff.dw_idx == 3'h3) // see [RL8]
        |=> (r_ff.p_base[2] == $past(pwdata_in[31:12])) && (r_ff.p_mocs[2] == $past(pwdata_in[11:8])))
        else $error("Dynamic dword not loaded");

    a_ind_load: assert property (col_load && (r_ff.dw_idx == 3'h4) // see [RL10]
        |=> (r_ff.p_base[3] == $past(pwdata_in[31:12])) && (r_ff.p_mocs[3] == $past(pwdata_in[11:8])))
        else $error("Indirect dword not loaded");

    a_instr_load: assert property (col_load && (r_ff.dw_idx == 3'h5) // see [RL22]
        |=> (r_ff.p_base[4] == $past(pwdata_in[31:12])) && (r_ff.p_mocs[4] == $past(pwdata_in[11:8])))
        else $error("Instruction dword not loaded");

    a_beyond_hold: assert property (col_fire && (r_ff.dw_idx == 3'h6) // see [RL1]
        |=> (r_ff.p_base == $past(r_ff.p_base)) && (r_ff.p_mocs == $past(r_ff.p_mocs)))
        else $error("Late dword changed state");

    a_flush_rise: assert property (col_fire && (r_ff.remain == 9'h001) // see [RL19]
        |=> flush_req_out && (r_ff.st == sba_pkg::SBA_FLUSH))
        else $error("Flush not requested");

    a_cmd_refuse: assert property ((r_ff.st == sba_pkg::SBA_FLUSH) && psel_in && !penable_in // see [RL19]
        && pwrite_in && (paddr_in == 8'h00) |=> pslverr_out)
        else $error("Command during flush accepted");

    a_commit_cnt: assert property ((r_ff.st == sba_pkg::SBA_FLUSH) && flush_done_in // see [RL19]
        |=> r_ff.commit_cnt == $past(r_ff.commit_cnt) + 8'h01)
        else $error("Commit not counted");

    a_mode_write: assert property (acc_fire && pwrite_in && (paddr_in == 8'h08) // see [RL15]
        |=> r_ff.cb_off_dis == $past(pwdata_in[0]))
        else $error("Mode write lost");

    a_sl_reloc: assert property (req_valid_in && (req_class_in == 4'h0) // see [RL13]
        |=> xlat_addr_out == {$past(r_ff.base[0]), 12'h000} + $past(req_offset_in))
        else $error("Stateless relocation wrong");

    a_sl_mocs: assert property (req_valid_in && (req_class_in == 4'h0) // see [RL4]
        |=> xlat_mocs_out == $past(r_ff.sl_mocs))
        else $error("Stateless control wrong");

    a_sl_wt: assert property (req_valid_in && (req_class_in == 4'h0) // see [RL5]
        |=> write_through_out == $past(r_ff.sl_wt && r_ff.sl_mocs[0]))
        else $error("Write policy wrong");

    a_dyn_mocs: assert property (req_valid_in && (req_class_in == 4'h2) // see [RL14]
        |=> xlat_mocs_out == $past(r_ff.mocs[2]))
        else $error("Dynamic control wrong");

    a_push_nobase: assert property (req_valid_in && (req_class_in == 4'h3) && r_ff.cb_off_dis // see [RL15]
        |=> xlat_addr_out == $past(req_offset_in))
        else $error("Push constant got a base");

    a_instr_reloc: assert property (req_valid_in && ((req_class_in == 4'h4) || (req_class_in == 4'h5)) // see [RL16]
        |=> xlat_addr_out == {$past(r_ff.base[4]), 12'h000} + $past(req_offset_in))
        else $error("Instruction relocation wrong");

    a_surf_reloc: assert property (req_valid_in && (req_class_in == 4'h6) // see [RL17]
        |=> xlat_addr_out == {$past(r_ff.base[1]), 12'h000} + $past(req_offset_in))
        else $error("Surface relocation wrong");

    a_ind_reloc: assert property (req_valid_in && (req_class_in == 4'h7) // see [RL10]
        |=> xlat_addr_out == {$past(r_ff.base[3]), 12'h000} + $past(req_offset_in))
        else $error("Indirect relocation wrong");

    a_none_mocs: assert property (req_valid_in && (req_class_in == 4'h8) // see [RL18]
        |=> xlat_mocs_out == $past(req_mocs_in))
        else $error("Unrelocated control wrong");

    a_flags_map: assert property (xlat_valid_out // see [RL21]
        |-> {display_data_flag_out, last_level_cache_ctrl_out, third_level_cache_ctrl_out} == xlat_mocs_out[2:0])
        else $error("Cache flags wrong");

    a_xlat_pulse: assert property (!req_valid_in // see [RL12]
        |=> !xlat_valid_out)
        else $error("Translation pulse stuck");

    c_hdr_accept: cover property ((r_ff.st == sba_pkg::SBA_IDLE) && cmd_fire && hdr_match);
    c_commit: cover property ((r_ff.st == sba_pkg::SBA_FLUSH) && flush_done_in);
    c_push_nobase: cover property (req_valid_in && (req_class_in == sba_pkg::SBA_CL_PUSH_CONST) && r_ff.cb_off_dis);
    c_cmd_refuse: cover property ((r_ff.st == sba_pkg::SBA_FLUSH) && psel_in && penable_in && pwrite_in);
    c_sl_wt: cover property (xlat_valid_out && write_through_out);

endmodule

// >>> dv/sba_pipe_model.sv
`timescale 1ns/1ps
module sba_pipe_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic flush_req_in,
    input wire logic [7:0] delay_in,
    output logic flush_done_out
);
    logic done_ff = 1'b0;
    logic [7:0] cnt_ff = 8'h00;
    assign flush_done_out = done_ff;
    // Pipeline drains, then acknowledges once per request
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_ff <= 1'b0;
            cnt_ff <= 8'h00;
        end else if (flush_req_in && !done_ff) begin
            if (cnt_ff >= delay_in) begin
                done_ff <= 1'b1;
                cnt_ff <= 8'h00;
            end else begin
                cnt_ff <= cnt_ff + 8'h01;
            end
        end else begin
            done_ff <= 1'b0;
        end
    end
endmodule

// >>> dv/test_sba_state_base.sv
`timescale 1ns/1ps
module test_sba_state_base;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, flush_req, flush_done, xv, f2, f1, f0, wt, e;
    logic req_valid = 1'b0;
    logic [3:0] req_class = 4'h0;
    logic [3:0] req_mocs = 4'h0;
    logic [31:0] req_offset = 32'h00000000;
    logic [31:0] xa, q;
    logic [3:0] xm;
    logic [7:0] delay = 8'h14;
    int errors = 0;
    int cmp_count = 0;
    logic [31:0] cmd [10] = '{32'h61010008, 32'h1234553B, 32'h222226FF, 32'h33333701, 32'h44444400,
        32'h55555201, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};

    always #2.5 clk_in = ~clk_in;

    sba_state_base dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .flush_req_out(flush_req), .flush_done_in(flush_done), .req_valid_in(req_valid),
        .req_class_in(req_class), .req_offset_in(req_offset), .req_mocs_in(req_mocs), .xlat_valid_out(xv),
        .xlat_addr_out(xa), .xlat_mocs_out(xm), .display_data_flag_out(f2), .last_level_cache_ctrl_out(f1),
        .third_level_cache_ctrl_out(f0), .write_through_out(wt));

    sba_pipe_model pipe (.clk_in(clk_in), .rst_n_in(rst_n_in), .flush_req_in(flush_req), .delay_in(delay),
        .flush_done_out(flush_done));

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk("pready", {31'h0, pready}, 32'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk("read data", q, exp);
        chk("read error", {31'h0, e}, 32'h0);
    endtask

    task automatic wrchk(input logic [31:0] d, input logic exp_err);
        apb(1'b1, 8'h00, d);
        chk("command error", {31'h0, e}, {31'h0, exp_err});
    endtask

    task automatic xl(input logic [3:0] c, input logic [3:0] m, input logic [31:0] base, input logic [3:0] em,
        input logic ewt);
        @(posedge clk_in);
        req_valid <= 1'b1;
        req_class <= c;
        req_offset <= 32'h00000ABC;
        req_mocs <= m;
        @(posedge clk_in);
        req_valid <= 1'b0;
        req_offset <= 32'h0F0F0F0F;
        @(negedge clk_in);
        chk("xlat valid", {31'h0, xv}, 32'h1);
        chk("xlat addr", xa, base + 32'h00000ABC);
        chk("xlat mocs", {28'h0, xm}, {28'h0, em});
        chk("cache flags", {29'h0, f2, f1, f0}, {29'h0, em[2:0]});
        chk("write through", {31'h0, wt}, {31'h0, ewt});
        @(posedge clk_in);
        @(negedge clk_in);
        chk("xlat pulse end", {31'h0, xv}, 32'h0);
        chk("xlat addr held", xa, base + 32'h00000ABC);
    endtask

    task automatic wait_flush;
        int n;
        n = 0;
        while (flush_req !== 1'b0 && n < 200) begin
            @(posedge clk_in);
            n++;
        end
        chk("flush released", {31'h0, flush_req}, 32'h0);
    endtask

    initial begin
        #50000;
        errors++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 5; i++) rdchk(8'(16 + 4 * i), 32'h00000000);
        xl(4'h0, 4'h0, 32'h00000000, 4'h0, 1'b0);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped error", {31'h0, e}, 32'h1);
        apb(1'b0, 8'h02, 32'h0);
        chk("misaligned error", {31'h0, e}, 32'h1);
        for (int i = 0; i < 10; i++) wrchk(cmd[i], 1'b0);
        @(posedge clk_in);
        chk("flush request", {31'h0, flush_req}, 32'h1);
        rdchk(8'h10, 32'h00000000);
        xl(4'h1, 4'h0, 32'h00000000, 4'h0, 1'b0);
        wrchk(cmd[0], 1'b1);
        apb(1'b0, 8'h04, 32'h0);
        chk("status pending", q & 32'h00FFFF03, 32'h00000002);
        wait_flush();
        rdchk(8'h10, 32'h12345538);
        rdchk(8'h14, 32'h22222600);
        rdchk(8'h18, 32'h33333700);
        rdchk(8'h1C, 32'h00000000);
        rdchk(8'h20, 32'h55555200);
        rdchk(8'h00, 32'h00000000);
        apb(1'b0, 8'h04, 32'h0);
        chk("status commit", q & 32'h00FFFF03, 32'h00010000);
        xl(4'h0, 4'hA, 32'h12345000, 4'h3, 1'b1);
        xl(4'h1, 4'hA, 32'h12345000, 4'h5, 1'b0);
        xl(4'h2, 4'hA, 32'h33333000, 4'h7, 1'b0);
        xl(4'h3, 4'hA, 32'h33333000, 4'hA, 1'b0);
        xl(4'h4, 4'hA, 32'h55555000, 4'h2, 1'b0);
        xl(4'h5, 4'hA, 32'h55555000, 4'h2, 1'b0);
        xl(4'h6, 4'hA, 32'h22222000, 4'h6, 1'b0);
        xl(4'h7, 4'hA, 32'h00000000, 4'h0, 1'b0);
        xl(4'h8, 4'hA, 32'h00000000, 4'hA, 1'b0);
        xl(4'hF, 4'h5, 32'h00000000, 4'h5, 1'b0);
        apb(1'b1, 8'h08, 32'h00000001);
        rdchk(8'h08, 32'h00000001);
        xl(4'h3, 4'h9, 32'h00000000, 4'h9, 1'b0);
        delay <= 8'h00;
        wrchk(32'h61020008, 1'b0);
        wrchk(32'h6101FF00, 1'b0);
        wrchk(32'hABCDE029, 1'b0);
        @(posedge clk_in);
        wait_flush();
        apb(1'b0, 8'h04, 32'h0);
        chk("status counts", q & 32'h00FFFF03, 32'h00020100);
        rdchk(8'h10, 32'hABCDE028);
        xl(4'h0, 4'h7, 32'hABCDE000, 4'h2, 1'b0);
        conclude();
    end
endmodule
